// *** include/rscd_pkg.sv ***
package rscd_pkg;

    // ----------------------------------------------------------------
    // Sizes and timing
    // ----------------------------------------------------------------
    localparam int REPLY_MAX = 32;
    localparam int REPLY_W = 8 * REPLY_MAX;
    localparam logic [2:0] CMD_DIGITS = 3'h6;
    localparam int CLK_PERIOD_NS = 5;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int MS_PRE_W = 18;

    // ----------------------------------------------------------------
    // Characters, commands and reply texts
    // ----------------------------------------------------------------
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_SOM = 8'h23;
    localparam logic [11:0] CMD_RDID = 12'h521;
    localparam logic [11:0] CMD_IO = 12'h526;
    localparam logic [11:0] CMD_RF = 12'h527;
    localparam logic [11:0] CMD_PRES = 12'h529;
    localparam logic [11:0] CMD_FILT = 12'h530;
    localparam logic [11:0] CMD_BADGE = 12'h532;
    localparam logic [11:0] CMD_BINT = 12'h533;
    localparam logic [11:0] CMD_CHG = 12'h560;
    localparam logic [11:0] CMD_MODE = 12'h570;
    localparam logic [11:0] CMD_BASIC = 12'h610;
    localparam logic [11:0] CMD_ECP = 12'h611;
    localparam logic [7:0] CMD_SETID = 8'h60;
    localparam logic [31:0] RF_STATE_REPLY_TAG = 32'h52465354;
    localparam logic [31:0] PRESENCE_STATE_REPLY_TAG = 32'h50525354;
    localparam logic [31:0] ID_FILTER_REPLY_TAG = 32'h52463053;
    localparam logic [23:0] BADGE_OUTPUT_MODE_REPLY_TAG = 24'h543046;
    localparam logic [23:0] BADGE_RETRANSMIT_INTERVAL_TAG = 24'h575449;
    localparam logic [31:0] INPUT_CHANGE_REPLY_TAG = 32'h53535443;
    localparam logic [47:0] TAG_MODE_ID_TAG = 48'h49543530303A;
    localparam logic [39:0] TAG_MODE_LEGACY_TAG = 40'h204154413A;
    localparam logic [31:0] READER_ID_TAG = 32'h52444944;
    localparam logic [31:0] IO_STATE_TAG = 32'h494F5354;
    localparam logic [31:0] DONE_TEXT = 32'h446F6E65;
    localparam logic [39:0] ERROR_TEXT = 40'h4572726F72;

    // ----------------------------------------------------------------
    // Field codes
    // ----------------------------------------------------------------
    localparam logic [1:0] SHUT_TIMEOUT = 2'h0;
    localparam logic [1:0] SHUT_TAG = 2'h1;
    localparam logic [1:0] SHUT_NOPRES = 2'h2;
    localparam logic [1:0] SEP_ALL = 2'h2;
    localparam logic [3:0] TMO_ZERO = 4'h0;
    localparam logic [3:0] TMO_NEVER = 4'hF;
    localparam logic [3:0] ATTEN_MIN = 4'hA;
    localparam logic [7:0] FREQ_MAX = 8'h34;
    localparam logic [2:0] MODE_EN = 3'h0;
    localparam logic [2:0] MODE_FULL = 3'h1;
    localparam logic [2:0] MODE_DIS = 3'h2;
    localparam logic [2:0] MODE_SORT = 3'h3;
    localparam logic [2:0] MODE_ID64 = 3'h4;

    // Timeout in ms per code; code 0 and code F are handled apart
    localparam logic [10:0] TMO_FAST_MS [16] = '{
        11'd0, 11'd48, 11'd48, 11'd48, 11'd48, 11'd48, 11'd48, 11'd48,
        11'd60, 11'd92, 11'd152, 11'd300, 11'd452, 11'd600, 11'd752,
        11'd0};
    localparam logic [10:0] TMO_SLOW_MS [16] = '{
        11'd0, 11'd150, 11'd150, 11'd150, 11'd150, 11'd150, 11'd150,
        11'd150, 11'd175, 11'd200, 11'd370, 11'd680, 11'd1000, 11'd1250,
        11'd1500, 11'd0};

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_RF = 4'h0;
    localparam logic [3:0] REG_PRES = 4'h4;
    localparam logic [3:0] REG_MISC = 4'h8;
    localparam logic [3:0] REG_STAT = 4'hC;
    localparam logic [31:0] RF_WMASK = 32'h3F1F1FFF;
    localparam logic [31:0] PRES_WMASK = 32'h0000F1F7;
    localparam logic [31:0] MISC_WMASK = 32'h007FFFFF;

    typedef struct packed {
        logic [1:0] rsvd3;
        logic rf_on;
        logic rf_src;
        logic [3:0] atten;
        logic [2:0] rsvd2;
        logic [4:0] rng_a;
        logic [2:0] rsvd1;
        logic [4:0] rng_l;
        logic [7:0] freq;
    } rscd_rf_reg_t;

    typedef struct packed {
        logic [15:0] rsvd3;
        logic [3:0] pulse;
        logic [2:0] rsvd2;
        logic inv;
        logic [3:0] tmo;
        logic rsvd1;
        logic [1:0] shutoff;
        logic pres_rpt;
    } rscd_pres_reg_t;

    typedef struct packed {
        logic [8:0] rsvd;
        logic [1:0] outs;
        logic pred;
        logic [2:0] tm_leg;
        logic [2:0] tm_id;
        logic [1:0] chg_sel;
        logic chg_en;
        logic [7:0] badge_int;
        logic badge_en;
        logic [1:0] sep;
    } rscd_misc_reg_t;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SEND} rscd_phase_t;

    typedef struct packed {
        rscd_phase_t phase;
        logic [23:0] cmd;
        logic [2:0] ndig;
        logic bad;
        logic [REPLY_W-1:0] msg;
        logic [5:0] left;
        rscd_rf_reg_t rf;
        rscd_pres_reg_t pres;
        rscd_misc_reg_t misc;
        logic [7:0] rdid;
        logic error_correcting_host_protocol;
        logic [2:0][1:0] sync;
        logic [1:0] ins;
        logic pres_d;
        logic tmr_run;
        logic expired;
        logic rf_out;
        logic [MS_PRE_W-1:0] ms_pre;
        logic [10:0] ms_cnt;
        logic [7:0] ncmd;
        logic [31:0] rdata;
    } rscd_state_t;

    localparam rscd_state_t ST_RESET = '{
        phase: ST_IDLE,
        rf: '{rng_l: 5'h1F, rng_a: 5'h1F, default: '0},
        pres: '{tmo: 4'hF, pulse: 4'hC, default: '0},
        misc: '{badge_int: 8'h01, tm_leg: 3'h2, default: '0},
        default: '0};

    // ----------------------------------------------------------------
    // Text helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] hexc(input logic [3:0] d);
        return (d < 4'hA) ? 8'h30 + {4'h0, d} : 8'h37 + {4'h0, d};
    endfunction

    function automatic logic [15:0] hex2(input logic [7:0] b);
        return {hexc(b[7:4]), hexc(b[3:0])};
    endfunction

    function automatic logic [7:0] mode_ch(input logic [2:0] m);
        case (m)
            MODE_EN: return 8'h45;
            MODE_FULL: return 8'h46;
            MODE_SORT: return 8'h4D;
            MODE_ID64: return 8'h49;
            default: return 8'h44;
        endcase
    endfunction

    // Right-aligned text of n bytes becomes left-aligned text plus CR LF
    function automatic logic [REPLY_W-1:0] fmt(input logic [REPLY_W-1:0] v,
                                               input logic [5:0] n);
        logic [REPLY_W-1:0] w;
        w = {v[REPLY_W-17:0], CH_CR, CH_LF};
        return w << (8 * (REPLY_MAX - 2 - int'(n)));
    endfunction

endpackage

// *** design/rscd_top.sv ***
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
// Notes on behaviour
// - RF reply: source, on/off, T1, frequency
// - RF reply carries legacy range 00-1F
// - RF reply carries alternate range 00-1F
// - RF reply carries attenuation 00 to 0A
// - Presence reply: report enable, fixed D0
// - Shutoff: timeout, timeout or tag, or presence
// - Timeout code 0 is always expired
// - Codes 1-7: 48 ms, legacy 150 ms
// - Code 8: 60 ms, legacy 175 ms
// - Code 9: 92 ms, legacy 200 ms
// - Code A: 152 ms, legacy 370 ms
// - Code B: 300 ms, legacy 680 ms
// - Code C: 452 ms, legacy 1000 ms
// - Code D: 600 ms, legacy 1250 ms
// - Code E: 752 ms, legacy 1500 ms
// - Code F is default, never expires
// - Presence reply reports input inversion, default off
// - Filter reply: separation mode, fixed V0
// - Change reply: enable and watched input
// - Tag mode reply: per-protocol letter codes
// - Set reader ID 00-FF, answer Done
// - I/O reply: output mode, outputs, inputs
module rscd_top
    import rscd_pkg::*;
#(
    parameter int CYC_PER_MS_P = CYC_PER_MS
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic [1:0] in_pin,
    input wire logic tag_seen,
    output logic [1:0] out_pin,
    output logic rf_enable,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);

    rscd_state_t s;
    rscd_state_t next_s;
    logic pres_now;
    logic legacy;
    logic [10:0] tmo_lim;

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rx_ready = s.phase == ST_IDLE;
    assign tx_valid = s.phase == ST_SEND;
    assign tx_data = s.msg[REPLY_W-1 -: 8];
    assign out_pin = s.misc.outs;
    assign rf_enable = s.rf_out;
    assign reg_rdata = s.rdata;

    // ----------------------------------------------------------------
    // Timeout limit
    // ----------------------------------------------------------------
    assign pres_now = s.ins[0] ^ s.pres.inv;
    assign legacy = s.misc.tm_id == MODE_DIS && s.misc.tm_leg != MODE_DIS;
    assign tmo_lim = legacy ? TMO_SLOW_MS[s.pres.tmo]
                            : TMO_FAST_MS[s.pres.tmo];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [3:0] nib;
        logic isx;
        logic [REPLY_W-1:0] txt;
        logic [5:0] tlen;
        next_s = s;
        nib = 4'h0;
        isx = 1'b0;
        txt = REPLY_W'(ERROR_TEXT);
        tlen = 6'h05;

        // Three stages; only the last two are compared
        next_s.sync = {s.sync[1:0], in_pin};
        for (int i = 0; i < 2; i++) begin
            if (s.sync[1][i] == s.sync[2][i]) begin
                next_s.ins[i] = s.sync[2][i];
            end
        end

        if (rx_data >= 8'h30 && rx_data <= 8'h39) begin
            nib = rx_data[3:0];
            isx = 1'b1;
        end else if ((rx_data | 8'h20) >= 8'h61
                     && (rx_data | 8'h20) <= 8'h66) begin
            nib = rx_data[3:0] + 4'h9;
            isx = 1'b1;
        end

        case (s.phase)
            ST_IDLE: begin
                if (rx_valid) begin
                    if (rx_data == CH_SOM) begin
                        next_s.cmd = '0;
                        next_s.ndig = 3'h0;
                        next_s.bad = 1'b0;
                    end else if (rx_data == CH_CR) begin
                        next_s.phase = ST_EXEC;
                    end else if (rx_data == CH_LF) begin
                        next_s.bad = s.bad;
                    end else if (isx && s.ndig < CMD_DIGITS) begin
                        next_s.cmd = {s.cmd[19:0], nib};
                        next_s.ndig = s.ndig + 3'h1;
                    end else begin
                        next_s.bad = 1'b1;
                    end
                end
            end
            ST_EXEC: begin
                next_s.phase = ST_SEND;
                next_s.cmd = '0;
                next_s.ndig = 3'h0;
                next_s.bad = 1'b0;
                next_s.ncmd = s.ncmd + 8'h01;
                if (!s.bad && s.ndig == 3'h3) begin
                    case (s.cmd[11:0])
                        CMD_RF: begin
                            txt = REPLY_W'({RF_STATE_REPLY_TAG,
                                " C", hexc({3'h0, s.rf.rf_src}),
                                " O", hexc({3'h0, s.rf_out}),
                                " T1", " F", hex2(s.rf.freq),
                                " R", hex2({3'h0, s.rf.rng_l}),
                                " G", hex2({3'h0, s.rf.rng_a}),
                                " A", hex2({4'h0, s.rf.atten})});
                            tlen = 6'd29;
                        end
                        CMD_PRES: begin
                            txt = REPLY_W'({PRESENCE_STATE_REPLY_TAG,
                                " P", hexc({3'h0, s.pres.pres_rpt}),
                                " D0",
                                " A", hexc({2'h0, s.pres.shutoff}),
                                " T", hexc(s.pres.tmo),
                                " I", hexc({3'h0, s.pres.inv})});
                            tlen = 6'd19;
                        end
                        CMD_FILT: begin
                            txt = REPLY_W'({ID_FILTER_REPLY_TAG,
                                " U", hexc({2'h0, s.misc.sep}),
                                " V0"});
                            tlen = 6'd10;
                        end
                        CMD_BADGE: begin
                            txt = REPLY_W'({BADGE_OUTPUT_MODE_REPLY_TAG,
                                " ", hexc({3'h0, s.misc.badge_en})});
                            tlen = 6'd5;
                        end
                        CMD_BINT: begin
                            txt = REPLY_W'({BADGE_RETRANSMIT_INTERVAL_TAG,
                                " ", hex2(s.misc.badge_int)});
                            tlen = 6'd6;
                        end
                        CMD_CHG: begin
                            txt = REPLY_W'({INPUT_CHANGE_REPLY_TAG,
                                " E", hexc({3'h0, s.misc.chg_en}),
                                " M", hexc({2'h0, s.misc.chg_sel})});
                            tlen = 6'd10;
                        end
                        CMD_MODE: begin
                            txt = REPLY_W'({TAG_MODE_ID_TAG,
                                mode_ch(s.misc.tm_id), TAG_MODE_LEGACY_TAG,
                                mode_ch(s.misc.tm_leg)});
                            tlen = 6'd13;
                        end
                        CMD_RDID: begin
                            txt = REPLY_W'({READER_ID_TAG, " ",
                                hex2(s.rdid)});
                            tlen = 6'd7;
                        end
                        CMD_IO: begin
                            txt = REPLY_W'({IO_STATE_TAG,
                                " C", hexc({3'h0, s.misc.pred}),
                                " O", hexc({2'h0, s.misc.outs}),
                                " I", hexc({2'h0, s.ins}),
                                " D", hexc(s.pres.pulse)});
                            tlen = 6'd16;
                        end
                        CMD_BASIC, CMD_ECP: begin
                            next_s.error_correcting_host_protocol = s.cmd[0];
                            txt = REPLY_W'(DONE_TEXT);
                            tlen = 6'd4;
                        end
                        default: begin
                            txt = REPLY_W'(ERROR_TEXT);
                            tlen = 6'd5;
                        end
                    endcase
                end else if (!s.bad && s.ndig == 3'h4
                             && s.cmd[15:8] == CMD_SETID) begin
                    next_s.rdid = s.cmd[7:0];
                    txt = REPLY_W'(DONE_TEXT);
                    tlen = 6'd4;
                end
                next_s.msg = fmt(txt, tlen);
                next_s.left = tlen + 6'd2;
            end
            ST_SEND: begin
                if (tx_ready) begin
                    next_s.msg = {s.msg[REPLY_W-9:0], 8'h00};
                    next_s.left = s.left - 6'd1;
                    if (s.left == 6'd1) begin
                        next_s.phase = ST_IDLE;
                    end
                end
            end
            default: begin
                next_s.phase = ST_IDLE;
            end
        endcase

        // ------------------------------------------------------------
        // RF timeout timer
        // ------------------------------------------------------------
        // Started by presence; only steers RF in input-driven mode
        next_s.pres_d = pres_now;
        next_s.rf_out = s.rf.rf_src ? s.tmr_run : s.rf.rf_on;
        if (s.tmr_run) begin
            if (s.ms_pre == MS_PRE_W'(CYC_PER_MS_P - 1)) begin
                next_s.ms_pre = '0;
                next_s.ms_cnt = s.ms_cnt + 11'h001;
            end else begin
                next_s.ms_pre = s.ms_pre + MS_PRE_W'(1);
            end
            if (s.pres.tmo != TMO_NEVER && s.ms_cnt >= tmo_lim) begin
                next_s.tmr_run = 1'b0;
                next_s.expired = 1'b1;
            end else if ((s.pres.shutoff == SHUT_TAG && tag_seen)
                         || (s.pres.shutoff == SHUT_NOPRES
                             && !pres_now)) begin
                next_s.tmr_run = 1'b0;
            end
        end
        if (pres_now && !s.pres_d) begin
            next_s.tmr_run = s.pres.tmo != TMO_ZERO;
            next_s.expired = s.pres.tmo == TMO_ZERO;
            next_s.ms_pre = '0;
            next_s.ms_cnt = 11'h000;
        end

        // ------------------------------------------------------------
        // Register port
        // ------------------------------------------------------------
        next_s.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                REG_RF: next_s.rdata = s.rf;
                REG_PRES: next_s.rdata = s.pres;
                REG_MISC: next_s.rdata = s.misc;
                REG_STAT: next_s.rdata = {8'h00, s.ncmd, 3'h0, s.ins,
                                          s.expired, s.rf_out, s.error_correcting_host_protocol,
                                          s.rdid};
                default: next_s.rdata = '0;
            endcase
        end
        if (reg_wr) begin
            case (reg_addr)
                REG_RF: begin
                    next_s.rf = rscd_rf_reg_t'(reg_wdata & RF_WMASK);
                    if (reg_wdata[27:24] > ATTEN_MIN) begin
                        next_s.rf.atten = s.rf.atten;
                    end
                    if (reg_wdata[7:0] > FREQ_MAX) begin
                        next_s.rf.freq = s.rf.freq;
                    end
                end
                REG_PRES: begin
                    next_s.pres = rscd_pres_reg_t'(reg_wdata & PRES_WMASK);
                    if (reg_wdata[2:1] > SHUT_NOPRES) begin
                        next_s.pres.shutoff = s.pres.shutoff;
                    end
                end
                REG_MISC: begin
                    next_s.misc = rscd_misc_reg_t'(reg_wdata & MISC_WMASK);
                    if (reg_wdata[10:3] == 8'h00) begin
                        next_s.misc.badge_int = s.misc.badge_int;
                    end
                    if (reg_wdata[1:0] > SEP_ALL) begin
                        next_s.misc.sep = s.misc.sep;
                    end
                end
                default: next_s.rdata = next_s.rdata;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s <= ST_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_cmd_end;
        rx_valid && rx_ready && rx_data == CH_CR;
    endsequence

    sequence s_last_byte;
        tx_valid && tx_ready && s.left == 6'd1;
    endsequence

    AST_RF_REPLY: assert property (
        s_cmd_end ##0 (!s.bad && s.ndig == 3'h3 && s.cmd[11:0] == CMD_RF)
        |-> ##2 (tx_valid && tx_data == RF_STATE_REPLY_TAG[31:24]
                 && s.left == 6'd31))
        else $error("RF status reply not started");

    AST_SET_ID: assert property (
        s_cmd_end ##0 (!s.bad && s.ndig == 3'h4 && s.cmd[15:8] == CMD_SETID)
        |-> ##2 (s.rdid == $past(s.cmd[7:0], 2)
                 && tx_data == DONE_TEXT[31:24] && s.left == 6'd6))
        else $error("Reader ID not stored or not acknowledged");

    AST_ERR_KEEP: assert property (
        s_cmd_end ##0 s.bad
        |-> ##2 (tx_data == ERROR_TEXT[39:32] && $stable(s.rdid)
                 && $stable(s.error_correcting_host_protocol)))
        else $error("Bad command not answered with error");

    AST_ONE_REPLY: assert property (
        s_last_byte |=> rx_ready && !tx_valid)
        else $error("Reply did not end after its last byte");

    AST_TMO_ZERO: assert property (
        pres_now && !s.pres_d && s.pres.tmo == TMO_ZERO
        |=> !s.tmr_run && s.expired ##1 !(s.rf.rf_src && rf_enable))
        else $error("Zero timeout did not expire at once");

    AST_TMO_NEVER: assert property (
        s.tmr_run && s.pres.tmo == TMO_NEVER
        && s.pres.shutoff == SHUT_TIMEOUT |=> s.tmr_run)
        else $error("Infinite timeout stopped");

    AST_TMO_BOUND: assert property (
        s.tmr_run && s.pres.tmo != TMO_NEVER |-> s.ms_cnt <= tmo_lim)
        else $error("RF timer ran past its limit");

    AST_NOPRES_OFF: assert property (
        s.tmr_run && s.pres.shutoff == SHUT_NOPRES && !pres_now
        |=> !s.tmr_run)
        else $error("RF kept on after presence loss");

    AST_RF_FIELDS: assert property (
        s.rf.atten <= ATTEN_MIN && s.rf.freq <= FREQ_MAX)
        else $error("Attenuation or frequency out of range");

endmodule // rscd_top

// *** testbench/rscd_host.sv ***
`timescale 1ns/1ps
module rscd_host
    import rscd_pkg::*;
(
    input wire logic clk,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic tx_ready
);
    logic slow = 1'b0;
    logic [REPLY_W-1:0] reply;
    int nrx;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b1;
    end
    // A slow host drops tx_ready every other cycle
    always @(posedge clk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (tx_valid && tx_ready) begin
            reply <= {reply[REPLY_W-9:0], tx_data};
            nrx <= nrx + 1;
        end
    end
    // ASCII characters, then CR; waits for the whole reply
    task automatic send(input string s);
        int n;
        reply = '0;
        nrx = 0;
        for (int i = 0; i <= s.len(); i++) begin
            rx_valid <= 1'b1;
            rx_data <= (i == s.len()) ? CH_CR : 8'(s[i]);
            #1;
            while (!rx_ready) begin
                @(posedge clk);
                #1;
            end
            @(posedge clk);
        end
        rx_valid <= 1'b0;
        // Released line must not keep showing the last byte
        rx_data <= ~rx_data;
        #1;
        for (n = 0; n < 400 && !rx_ready; n++) begin
            @(posedge clk);
            #1;
        end
    endtask
endmodule // rscd_host

// *** testbench/reader_status_command_decoder_bench.sv ***
`timescale 1ns/1ps
module reader_status_command_decoder_bench
    import rscd_pkg::*;
;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic rx_valid, rx_ready, tx_valid, tx_ready, rf_enable;
    logic reg_wr = 1'b0, reg_rd = 1'b0, tag_seen = 1'b0;
    logic [7:0] rx_data, tx_data;
    logic [1:0] in_pin = 2'h0, out_pin;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    int miscompares = 0, checks_done = 0;
    always #2.5 core_clk = ~core_clk;
    // Short ms prescale keeps timer runs brief
    rscd_top #(.CYC_PER_MS_P(4)) DUT (.core_clk, .rstn, .rx_valid,
        .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready, .in_pin,
        .tag_seen, .out_pin, .rf_enable, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata);
    rscd_host host (.clk(core_clk), .rx_ready, .tx_valid, .tx_data,
        .rx_valid, .rx_data, .tx_ready);
    // ----------------------------------------------------------------
    // Access and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [REPLY_W-1:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
        @(posedge core_clk);
    endtask
    task automatic say(input string s, input logic [REPLY_W-1:0] e,
                       input int n);
        host.send(s);
        chk(host.reply, e);
        chk(host.nrx, n);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        rd(REG_RF, 32'h001F1F00);
        rd(REG_PRES, 32'h0000C0F0);
        rd(REG_MISC, 32'h00040008);
        rd(4'h1, 32'h0);
        say("521", {READER_ID_TAG, " 00", CH_CR, CH_LF}, 9);
        say("60A5", {DONE_TEXT, CH_CR, CH_LF}, 6);
        host.slow = 1'b1;
        say("999", {ERROR_TEXT, CH_CR, CH_LF}, 7);
        say("5X7", {ERROR_TEXT, CH_CR, CH_LF}, 7);
        say("521", {READER_ID_TAG, " A5", CH_CR, CH_LF}, 9);
        wr(REG_RF, 32'h3B150735);
        say("527", {RF_STATE_REPLY_TAG, " C1 O0 T1 F00 R07 G15 A00",
            CH_CR, CH_LF}, 31);
        rd(REG_RF, 32'h30150700);
        wr(REG_PRES, 32'h00000195);
        say("529", {PRESENCE_STATE_REPLY_TAG, " P1 D0 A2 T9 I1",
            CH_CR, CH_LF}, 21);
        chk(rf_enable, 1'b1);
        wr(REG_MISC, 32'h0062FA06);
        say("530", {ID_FILTER_REPLY_TAG, " U2 V0", CH_CR, CH_LF}, 12);
        say("532", {BADGE_OUTPUT_MODE_REPLY_TAG, " 1", CH_CR, CH_LF},
            7);
        say("533", {BADGE_RETRANSMIT_INTERVAL_TAG, " 40", CH_CR, CH_LF},
            8);
        say("560", {INPUT_CHANGE_REPLY_TAG, " E1 M3", CH_CR, CH_LF},
            12);
        say("570", {TAG_MODE_ID_TAG, "M", TAG_MODE_LEGACY_TAG, "F",
            CH_CR, CH_LF}, 15);
        @(posedge core_clk);
        in_pin <= 2'h2;
        // Long enough for the code 9 timeout to run out
        repeat (400) @(posedge core_clk);
        chk(rf_enable, 1'b0);
        wr(REG_PRES, 32'h00000000);
        wr(REG_PRES, 32'h00000100);
        chk(rf_enable, 1'b0);
        say("526", {IO_STATE_TAG, " C0 O3 I2 D0", CH_CR, CH_LF},
            18);
        chk(out_pin, 2'h3);
        rd(REG_STAT, 32'h000D14A5);
        end_of_test();
    end
endmodule // reader_status_command_decoder_bench
